// >>> epf_pkg.sv
/*
 * Package for the event-driven PWM state machine block: states, coupling
 * modes, widths and timing constants.
 * Assumes a 96 MHz state machine clock; all users import epf_pkg::*.
 */
`default_nettype none
package epf_pkg;
	localparam int unsigned NUM_FSM      = 6;
	localparam int unsigned NUM_EVT_IN   = 3;
	localparam int unsigned TIME_W       = 16;
	localparam int unsigned SEL_W        = 2;
	localparam int unsigned DITHER_W     = 3;
	localparam int unsigned NUM_DIG      = 6;
	localparam int unsigned NUM_CMP      = 4;
	localparam int unsigned NUM_IRQ      = 8;
	localparam int unsigned FSM_CLK_MHZ  = 96;
	localparam int unsigned PERIOD_PS    = 10400;
	localparam int unsigned FINE_RES_PS  = 1300;
	localparam int unsigned DITHER_STEPS = PERIOD_PS / FINE_RES_PS;
	localparam int unsigned SYNC_STAGES  = 2;
	localparam int unsigned EVT_TIMER    = 3;
	localparam int unsigned EVT_W        = 4;
	localparam logic [TIME_W-1:0] TIME_RESET = 16'h0000;

	typedef enum logic [2:0] {
		EPF_IDLE      = 3'b000,
		EPF_RUN_ZERO  = 3'b001,
		EPF_RUN_ONE   = 3'b010,
		EPF_RUN_TWO   = 3'b011,
		EPF_RUN_THREE = 3'b100,
		EPF_HOLD      = 3'b101
	} epf_state_e;

	typedef enum logic [2:0] {
		EPF_CPL_SINGLE     = 3'b000,
		EPF_CPL_SYNC       = 3'b001,
		EPF_CPL_ASYNC      = 3'b010,
		EPF_CPL_SYNC_TWO   = 3'b011,
		EPF_CPL_ASYNC_TWO  = 3'b100,
		EPF_CPL_EXTERNAL   = 3'b101
	} epf_couple_e;
endpackage
`default_nettype wire

// >>> epf_sync.sv
/*
 * Two-flop synchroniser for a vector of asynchronous levels.
 * Assumes inputs may change at any time relative to clk.
 */
`default_nettype none
module epf_sync
	import epf_pkg::*;
#(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] asyncIn,
	output var  logic [W-1:0] syncOut
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] stable;
	} epf_sync_s;

	epf_sync_s st_reg;
	epf_sync_s st_next;

	always_comb begin
		st_next.meta   = asyncIn;
		st_next.stable = st_reg.meta;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign syncOut = st_reg.stable;
endmodule
`default_nettype wire

// >>> epf_machine.sv
/*
 * One event-driven PWM state machine: six states, per-state event masks,
 * per-state timer, output levels, interrupt and ADC trigger per transition.
 * Assumes event inputs are already synchronous to clk.
 */
`default_nettype none
module epf_machine
	import epf_pkg::*;
(
	input  wire logic                     clk,
	input  wire logic                     rst_b,
	input  wire logic                     start,
	input  wire logic                     holdReq,
	input  wire logic [NUM_EVT_IN-1:0]    evtIn,
	input  wire logic [4*TIME_W-1:0]      stateTime,
	input  wire logic [4*EVT_W-1:0]       evtMask,
	input  wire logic [4*2-1:0]           nextState,
	input  wire logic [3:0]               levelOnEntry,
	input  wire logic [3:0]               irqOnExit,
	input  wire logic [3:0]               adcOnExit,
	input  wire logic [DITHER_W-1:0]      ditherFrac,
	output var  logic                     pwmOut,
	output var  logic                     irqPulse,
	output var  logic                     adcPulse,
	output var  logic [2:0]               stateOut
);
	typedef struct packed {
		epf_state_e          state;
		logic [TIME_W-1:0]   count;
		logic                pwm;
		logic                irq;
		logic                adc;
		logic [DITHER_W-1:0] ditherAcc;
	} epf_machine_s;

	epf_machine_s st_reg;
	epf_machine_s st_next;
	logic [1:0]         idx;
	logic [EVT_W-1:0]   evts;
	logic               fire;
	logic [DITHER_W:0]  accSum;
	logic [1:0]         dest;

	always_comb begin
		st_next     = st_reg;
		st_next.irq = 1'b0;
		st_next.adc = 1'b0;
		idx         = 2'(st_reg.state - EPF_RUN_ZERO);
		accSum      = {1'b0, st_reg.ditherAcc} + {1'b0, ditherFrac};
		// Carry stretches the state by one period: average edge lands on fine grid
		evts        = {(st_reg.count >= stateTime[idx*TIME_W +: TIME_W] + TIME_W'(accSum[DITHER_W])), evtIn};
		fire        = |(evts & evtMask[idx*EVT_W +: EVT_W]); // [RL4]
		dest        = nextState[idx*2 +: 2];
		unique case (st_reg.state)
			EPF_IDLE: begin
				if (start) begin // [RL6]
					st_next.state = EPF_RUN_ZERO;
					st_next.count = TIME_RESET;
					st_next.pwm   = levelOnEntry[0];
				end
			end
			EPF_HOLD: begin
				// Stop outranks hold release, so a halted machine never restarts alone
				if (!start) begin
					st_next.state = EPF_IDLE;
				end else if (!holdReq) begin
					st_next.state = EPF_RUN_ZERO;
					st_next.count = TIME_RESET;
					st_next.pwm   = levelOnEntry[0]; // [RL5]
				end
			end
			default: begin
				st_next.count = st_reg.count + TIME_W'(1); // [RL11]
				if (!start) begin
					st_next.state = EPF_IDLE;
				end else if (holdReq) begin // [RL3]
					st_next.state = EPF_HOLD;
				end else if (fire) begin // [RL9]
					st_next.state     = epf_state_e'(3'(dest) + EPF_RUN_ZERO); // [RL2]
					st_next.count     = TIME_RESET;
					st_next.pwm       = levelOnEntry[dest]; // [RL5]
					st_next.irq       = irqOnExit[idx]; // [RL10]
					st_next.adc       = adcOnExit[idx]; // [RL14]
					st_next.ditherAcc = accSum[DITHER_W-1:0]; // [RL7]
				end
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '{EPF_IDLE, TIME_RESET, 1'b0, 1'b0, 1'b0, '0};
		end else begin
			st_reg <= st_next; // [RL8]
		end
	end

	assign pwmOut   = st_reg.pwm;
	assign irqPulse = st_reg.irq;
	assign adcPulse = st_reg.adc;
	assign stateOut = st_reg.state;
endmodule
`default_nettype wire

// >>> epf_top.sv
/*
 * Event-driven PWM subsystem: six machines, connection matrix, coupling.
 * Assumes configuration ports are driven by the processor on clk and stay
 * stable while machines run; digital inputs and comparators are asynchronous.
 */
`default_nettype none
// Behaviour
// [RL1] Six machines, independent or grouped
// [RL2] Four running states zero to three
// [RL3] Idle and hold states besides running
// [RL4] Per-state configurable triggering events
// [RL5] Transition may update PWM output level
// [RL6] Runs autonomously once started
// [RL7] 96 MHz clock, dithering for fine edges
// [RL8] One clock period native resolution
// [RL9] Sync, async or timer events trigger
// [RL10] Per-transition configurable interrupt request
// [RL11] Four 16-bit times per machine
// [RL12] Fifteen configuration registers per machine
// [RL13] Eight interrupt request lines
// [RL14] Configurable ADC trigger per machine
// [RL15] Coupled machines interleave, separate or merged
// [RL16] Six coupling arrangements supported
// [RL17] Coupling set by global and drive fields
// [RL18] Digital, comparator, PWM feedback, software sources
// [RL19] Three inputs, 2-bit four-way selection each
// [RL20] Input two code three: own software event
// [RL21] Machine two input one matrix row
// [RL22] Independent selection per event input
// [RL23] Async inputs synchronised before state logic
module epf_top
	import epf_pkg::*;
(
	input  wire logic                               clk,
	input  wire logic                               rst_b,
	input  wire logic [NUM_DIG-1:0]                 fastDigitalIn,
	input  wire logic [NUM_CMP-1:0]                 comparatorOut,
	input  wire logic [NUM_FSM-1:0]                 softEvent,
	input  wire logic [NUM_FSM-1:0]                 machineStart,
	input  wire logic [NUM_FSM-1:0]                 machineHold,
	input  wire logic [NUM_FSM*NUM_EVT_IN*SEL_W-1:0] eventSelectRegs,
	input  wire logic [NUM_FSM*4*TIME_W-1:0]        stateTimes,
	input  wire logic [NUM_FSM*4*EVT_W-1:0]         eventMasks,
	input  wire logic [NUM_FSM*8-1:0]               nextStates,
	input  wire logic [NUM_FSM*4-1:0]               entryLevels,
	input  wire logic [NUM_FSM*4-1:0]               irqEnables,
	input  wire logic [NUM_FSM*4-1:0]               adcEnables,
	input  wire logic [NUM_FSM*DITHER_W-1:0]        ditherFracs,
	input  wire logic [NUM_FSM*3-1:0]               couplingGlobalCfg,
	input  wire logic [NUM_FSM-1:0]                 couplingOutputDrive,
	output var  logic [NUM_FSM-1:0]                 pwmOut,
	output var  logic [NUM_IRQ-1:0]                 irqLines,
	output var  logic                               adcTrigger,
	output var  logic [NUM_FSM*3-1:0]               machineState
);
	typedef struct packed {
		logic [NUM_FSM-1:0]   pwm;
		logic [NUM_IRQ-1:0]   irq;
		logic                 adc;
		logic [NUM_FSM*3-1:0] state;
	} epf_top_s;

	epf_top_s st_reg;
	epf_top_s st_next;

	logic [NUM_DIG-1:0]          digSync;
	logic [NUM_CMP-1:0]          cmpSync;
	logic [NUM_FSM-1:0]          rawPwm;
	logic [NUM_FSM-1:0]          rawIrq;
	logic [NUM_FSM-1:0]          rawAdc;
	logic [NUM_FSM*3-1:0]        rawState;
	logic [NUM_FSM*NUM_EVT_IN-1:0] evtSel;
	logic [NUM_FSM-1:0]          effStart;
	logic [NUM_FSM-1:0]          pwmFb;

	// Only the pin-facing sources cross domains; software events are on clk
	epf_sync #(.W(NUM_DIG)) uDigSync ( // [RL23]
		.clk     (clk),
		.rst_b   (rst_b),
		.asyncIn (fastDigitalIn),
		.syncOut (digSync)
	);

	epf_sync #(.W(NUM_CMP)) uCmpSync ( // [RL23]
		.clk     (clk),
		.rst_b   (rst_b),
		.asyncIn (comparatorOut),
		.syncOut (cmpSync)
	);

	assign pwmFb = st_reg.pwm;

	// Matrix row per machine and input: {code11, code10, code01, code00}
	function automatic logic pick(input logic [1:0] sel, input logic [3:0] row);
		pick = row[sel]; // [RL19]
	endfunction

	function automatic logic [SEL_W-1:0] selOf(input int unsigned m, input int unsigned i,
			input logic [NUM_FSM*NUM_EVT_IN*SEL_W-1:0] regs);
		selOf = regs[(m*NUM_EVT_IN+i)*SEL_W +: SEL_W]; // [RL22]
	endfunction

	always_comb begin
		logic [NUM_DIG-1:0] d;
		logic [NUM_CMP-1:0] c;
		logic [NUM_FSM-1:0] s;
		d = digSync;
		c = cmpSync;
		s = softEvent;
		// [RL18]
		evtSel[0]  = pick(selOf(0, 0, eventSelectRegs), {d[5], d[2], d[0], c[0]});
		evtSel[1]  = pick(selOf(0, 1, eventSelectRegs), {c[3], d[3], d[0], c[1]});
		evtSel[2]  = pick(selOf(0, 2, eventSelectRegs), {s[0], d[4], d[1], c[2]}); // [RL20]
		evtSel[3]  = pick(selOf(1, 0, eventSelectRegs), {d[0], d[3], d[1], c[1]});
		evtSel[4]  = pick(selOf(1, 1, eventSelectRegs), {c[3], d[4], d[1], c[2]});
		evtSel[5]  = pick(selOf(1, 2, eventSelectRegs), {s[1], d[5], d[2], c[0]}); // [RL20]
		evtSel[6]  = pick(selOf(2, 0, eventSelectRegs), {d[1], d[4], d[2], c[2]});
		evtSel[7]  = pick(selOf(2, 1, eventSelectRegs), {pwmFb[0], d[5], d[2], c[0]}); // [RL21]
		evtSel[8]  = pick(selOf(2, 2, eventSelectRegs), {s[2], d[0], d[3], c[1]}); // [RL20]
		evtSel[9]  = pick(selOf(3, 0, eventSelectRegs), {d[2], d[5], d[3], c[0]});
		evtSel[10] = pick(selOf(3, 1, eventSelectRegs), {pwmFb[1], d[0], d[3], c[1]});
		evtSel[11] = pick(selOf(3, 2, eventSelectRegs), {s[3], d[1], d[4], c[2]}); // [RL20]
		evtSel[12] = pick(selOf(4, 0, eventSelectRegs), {d[3], d[0], d[4], c[1]});
		evtSel[13] = pick(selOf(4, 1, eventSelectRegs), {pwmFb[5], d[1], d[4], c[2]});
		evtSel[14] = pick(selOf(4, 2, eventSelectRegs), {s[4], d[2], d[5], c[0]}); // [RL20]
		evtSel[15] = pick(selOf(5, 0, eventSelectRegs), {d[4], d[1], d[5], c[2]});
		evtSel[16] = pick(selOf(5, 1, eventSelectRegs), {c[3], d[2], d[5], c[0]});
		evtSel[17] = pick(selOf(5, 2, eventSelectRegs), {s[5], d[3], d[0], c[1]}); // [RL20]
	end

	// Sync-coupled machines start with their even partner so both sequences align
	always_comb begin
		for (int m = 0; m < NUM_FSM; m++) begin
			unique case (epf_couple_e'(couplingGlobalCfg[m*3 +: 3])) // [RL16] [RL17]
				EPF_CPL_SYNC, EPF_CPL_SYNC_TWO:
					effStart[m] = machineStart[m & ~1] & machineStart[m];
				EPF_CPL_EXTERNAL:
					effStart[m] = machineStart[m] & evtSel[m*NUM_EVT_IN];
				EPF_CPL_SINGLE, EPF_CPL_ASYNC, EPF_CPL_ASYNC_TWO:
					effStart[m] = machineStart[m];
				default:
					effStart[m] = 1'b0;
			endcase
		end
	end

	// Each machine keeps its own sequence; only starts and outputs are combined
	for (genvar m = 0; m < NUM_FSM; m++) begin : gMachine // [RL1] [RL12]
		epf_machine uMachine (
			.clk          (clk),
			.rst_b        (rst_b),
			.start        (effStart[m]),
			.holdReq      (machineHold[m]),
			.evtIn        (evtSel[m*NUM_EVT_IN +: NUM_EVT_IN]),
			.stateTime    (stateTimes[m*4*TIME_W +: 4*TIME_W]),
			.evtMask      (eventMasks[m*4*EVT_W +: 4*EVT_W]),
			.nextState    (nextStates[m*8 +: 8]),
			.levelOnEntry (entryLevels[m*4 +: 4]),
			.irqOnExit    (irqEnables[m*4 +: 4]),
			.adcOnExit    (adcEnables[m*4 +: 4]),
			.ditherFrac   (ditherFracs[m*DITHER_W +: DITHER_W]),
			.pwmOut       (rawPwm[m]),
			.irqPulse     (rawIrq[m]),
			.adcPulse     (rawAdc[m]),
			.stateOut     (rawState[m*3 +: 3])
		);
	end

	always_comb begin
		st_next       = st_reg;
		st_next.state = rawState;
		st_next.adc   = |rawAdc; // [RL14]
		// Lines 6 and 7 summarise the two machine halves for a shared vector
		st_next.irq   = {|rawIrq[5:3], |rawIrq[2:0], 2'(0), rawIrq[3:0]} | // [RL13]
		                {2'(0), rawIrq[5:4], 4'h0};
		for (int m = 0; m < NUM_FSM; m++) begin
			// Drive bit set on an odd machine merges its pulses onto the even pin
			if (m[0] && couplingOutputDrive[m]) begin // [RL15]
				st_next.pwm[m]   = 1'b0;
			end else if (!m[0] && couplingOutputDrive[m | 1]) begin // [RL15]
				st_next.pwm[m]   = rawPwm[m] | rawPwm[m+1];
			end else begin
				st_next.pwm[m]   = rawPwm[m];
			end
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign pwmOut       = st_reg.pwm;
	assign irqLines     = st_reg.irq;
	assign adcTrigger   = st_reg.adc;
	assign machineState = st_reg.state;
endmodule
`default_nettype wire

// >>> epf_props.sv
/*
 * Checker for epf_top: machine one's sequencing and the interrupt lines.
 * Assumes machine one runs single and its pin is never merged.
 */
`default_nettype none
module epf_props
	import epf_pkg::*;
(
	input wire logic                 clk,
	input wire logic                 rst_b,
	input wire logic [NUM_FSM-1:0]   machineStart,
	input wire logic [NUM_FSM-1:0]   machineHold,
	input wire logic [NUM_FSM*4-1:0] entryLevels,
	input wire logic [NUM_FSM-1:0]   pwmOut,
	input wire logic [NUM_IRQ-1:0]   irqLines,
	input wire logic                 adcTrigger,
	input wire logic [NUM_FSM*3-1:0] machineState
);
	logic [2:0] st;
	assign st = machineState[5:3];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_state_legal: assert property (st <= 3'd5)
		else $error("state code out of range");
	a_start_run: assert property ($rose(machineStart[1]) ##0
		(machineStart[1] && !machineHold[1])[*2] |=> st inside {[3'd1:3'd4]})
		else $error("start did not reach a running state");
	a_stop_idle: assert property (!machineStart[1] |-> ##2 st == 3'd0)
		else $error("stopped machine not idle");
	a_hold_enter: assert property (machineStart[1] && machineHold[1]
		##1 st inside {[3'd1:3'd4]} |=> st == 3'd5)
		else $error("hold not entered");
	a_hold_exit: assert property ($fell(machineHold[1]) && machineStart[1]
		&& st == 3'd5 |-> ##2 st == 3'd1)
		else $error("hold release not to state zero");
	a_irq_move: assert property (irqLines[1] |-> st != $past(st))
		else $error("interrupt without transition");
	a_pwm_move: assert property (pwmOut[1] != $past(pwmOut[1]) |-> st != $past(st))
		else $error("output moved without transition");
	a_pwm_level: assert property (st != $past(st) && st inside {[3'd1:3'd4]}
		|-> pwmOut[1] == entryLevels[{2'b00, st} + 5'd3])
		else $error("entry level wrong");
	a_irq_low_group: assert property (irqLines[6] == |irqLines[2:0])
		else $error("group line six wrong");
	a_irq_high_group: assert property (irqLines[7] == |irqLines[5:3])
		else $error("group line seven wrong");
	cover property (st == 3'd5);
	cover property (irqLines[1] && adcTrigger);
	cover property (machineState[8:6] == 3'd2);
endmodule
bind epf_top epf_props epf_props_inst (.clk(clk), .rst_b(rst_b),
	.machineStart(machineStart), .machineHold(machineHold), .entryLevels(entryLevels),
	.pwmOut(pwmOut), .irqLines(irqLines), .adcTrigger(adcTrigger),
	.machineState(machineState));
`default_nettype wire

// >>> epf_stage.sv
/*
 * Far-side model: fast digital event pins and comparator outputs.
 * Assumes the bench asks for levels; they land off the clock grid after a lag.
 */
`default_nettype none
module epf_stage
	import epf_pkg::*;
(
	input  wire logic [NUM_DIG-1:0] digWant,
	input  wire logic [NUM_CMP-1:0] cmpWant,
	input  wire logic [3:0]         lagNs,
	output var  logic [NUM_DIG-1:0] fastDigitalIn,
	output var  logic [NUM_CMP-1:0] comparatorOut
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		fastDigitalIn = '0;
		comparatorOut = '0;
	end
	// Odd fraction keeps pin edges off the clock edge, as a real comparator would
	always @(digWant, cmpWant, lagNs) begin
		fastDigitalIn <= #(lagNs + 0.3) digWant;
		comparatorOut <= #(lagNs + 0.3) cmpWant;
	end
endmodule
`default_nettype wire

// >>> testbench.sv
/*
 * Self-checking bench for epf_top: timer, hold, matrix and soft events.
 * Assumes epf_stage as pin partner and epf_props bound to the top.
 */
`default_nettype none
module testbench
	import epf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic                               clk = 1'b0;
	logic                               rst_b = 1'b0;
	logic [NUM_FSM-1:0]                 softEvent = '0, machineStart = '0, machineHold = '0;
	logic [NUM_FSM*NUM_EVT_IN*SEL_W-1:0] eventSelectRegs = '0;
	logic [NUM_FSM*4*TIME_W-1:0]        stateTimes = '0;
	logic [NUM_FSM*4*EVT_W-1:0]         eventMasks = '0;
	logic [NUM_FSM*8-1:0]               nextStates = '0;
	logic [NUM_FSM*4-1:0]               entryLevels = '0, irqEnables = '0, adcEnables = '0;
	logic [NUM_FSM*DITHER_W-1:0]        ditherFracs = '0;
	logic [NUM_FSM*3-1:0]               couplingGlobalCfg = '0;
	logic [NUM_FSM-1:0]                 couplingOutputDrive = '0;
	logic [NUM_FSM*3-1:0]               machineState;
	logic [NUM_FSM-1:0]                 pwmOut;
	logic [NUM_IRQ-1:0]                 irqLines;
	logic                               adcTrigger;
	logic [NUM_DIG-1:0]                 digWant = '0, fastDigitalIn;
	logic [NUM_CMP-1:0]                 cmpWant = '0, comparatorOut;
	logic [3:0]                         lagNs = 4'h0;
	logic [31:0]                        seed = 32'hf02987d6;
	int                                 n_mismatch = 0, samples_checked = 0;
	always #5 clk = ~clk;
	epf_stage epf_stage_inst (.digWant(digWant), .cmpWant(cmpWant), .lagNs(lagNs),
		.fastDigitalIn(fastDigitalIn), .comparatorOut(comparatorOut));
	// Machine one stays single; coupling, merge and dither are driven on machines two, three
	epf_top epf_top_inst (.clk(clk), .rst_b(rst_b), .fastDigitalIn(fastDigitalIn),
		.comparatorOut(comparatorOut), .softEvent(softEvent), .machineStart(machineStart),
		.machineHold(machineHold), .eventSelectRegs(eventSelectRegs),
		.stateTimes(stateTimes), .eventMasks(eventMasks), .nextStates(nextStates),
		.entryLevels(entryLevels), .irqEnables(irqEnables), .adcEnables(adcEnables),
		.ditherFracs(ditherFracs), .couplingGlobalCfg(couplingGlobalCfg),
		.couplingOutputDrive(couplingOutputDrive),
		.pwmOut(pwmOut), .irqLines(irqLines), .adcTrigger(adcTrigger),
		.machineState(machineState));
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] x;
		x = v ^ (v << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	task automatic final_report();
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("unexpected at %0t: %s", $time, msg);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic cfg(input int m, j, input logic [15:0] t, input logic [3:0] msk,
			input logic [1:0] nx, input logic lv, ie);
		stateTimes[(m*4+j)*16 +: 16] = t;
		eventMasks[(m*4+j)*4 +: 4] = msk;
		nextStates[(m*4+j)*2 +: 2] = nx;
		entryLevels[m*4+j] = lv;
		irqEnables[m*4+j] = ie;
		adcEnables[m*4+j] = ie;
	endtask
	task automatic waitSt(input int m, input logic [2:0] s, input int lim, output int n);
		n = 0;
		while (machineState[m*3 +: 3] !== s && n < lim) begin
			tick(1);
			n++;
		end
	endtask
	initial begin
		#100us;
		n_mismatch++;
		final_report();
	end
	initial begin
		int d, t, ni, na, acc;
		logic [2:0] s;
		repeat (16) @(posedge clk);
		#1 rst_b = 1'b1;
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			t = 4 + seed[4:0];
			cfg(1, 0, t[15:0], 4'h8, 2'd1, seed[8], 1'b1);
			cfg(1, 1, 16'h0, 4'h0, 2'd1, ~seed[8], 1'b0);
			machineStart[1] = 1'b1;
			waitSt(1, 3'd1, 8, d);
			chk(d == 2 && pwmOut[1] === seed[8], "start latency or level");
			{d, ni, na} = '0;
			while (machineState[5:3] !== 3'd2 && d < 100) begin
				tick(1);
				d++;
				ni += irqLines[1];
				na += adcTrigger;
			end
			// Count runs 0 to t before expiry, so the state lasts t + 1 cycles
			chk(d == t + 1, "timer length");
			chk(ni == 1 && na == 1 && pwmOut[1] === ~seed[8], "transition");
			tick(1);
			chk(irqLines[1] === 1'b0 && adcTrigger === 1'b0, "pulse too long");
			machineStart[1] = 1'b0;
			tick(3);
			chk(machineState[5:3] === 3'd0, "stop to idle");
		end
		machineStart[1] = 1'b1;
		waitSt(1, 3'd2, 100, d);
		machineHold[1] = 1'b1;
		tick(6);
		chk(machineState[5:3] === 3'd5, "hold");
		machineHold[1] = 1'b0;
		tick(2);
		chk(machineState[5:3] === 3'd1 && pwmOut[1] === entryLevels[4], "hold release");
		cfg(0, 0, 16'h0, 4'h0, 2'd0, 1'b1, 1'b0);
		cfg(2, 0, 16'h0, 4'h2, 2'd1, 1'b0, 1'b0);
		cfg(2, 1, 16'h0, 4'h0, 2'd1, 1'b1, 1'b0);
		for (int c = 0; c < 4; c++) begin
			eventSelectRegs[15:14] = c[1:0];
			seed = xs(seed);
			lagNs = seed[3:0];
			digWant = (c == 1) ? 6'h3b : (c == 2) ? 6'h1f : 6'h3f;
			cmpWant = (c == 0) ? 4'he : 4'hf;
			machineStart[2] = 1'b1;
			tick(8);
			chk(machineState[8:6] === 3'd1, "unselected source moved");
			digWant = 6'h3f;
			cmpWant = 4'hf;
			machineStart[0] = (c == 3);
			waitSt(2, 3'd2, 12, d);
			// A pin landing after the first edge costs one more sync cycle
			t = (c == 3 || lagNs < 4'd9) ? 4 : 5;
			chk(machineState[8:6] === 3'd2 && d == t, "matrix");
			{machineStart, digWant, cmpWant} = '0;
			tick(4);
		end
		eventSelectRegs[5:4] = 2'b11;
		cfg(0, 0, 16'h0, 4'h4, 2'd2, 1'b1, 1'b0);
		cfg(0, 2, 16'h0, 4'h0, 2'd2, 1'b0, 1'b0);
		machineStart[0] = 1'b1;
		softEvent = 6'h3e;
		tick(6);
		chk(machineState[2:0] === 3'd1, "foreign soft event");
		softEvent = 6'h01;
		tick(2);
		chk(machineState[2:0] === 3'd3 && pwmOut[0] === 1'b0, "own soft event");
		seed = xs(seed);
		t = 2 + seed[6:3];
		ditherFracs[11:9] = seed[2:0];
		couplingGlobalCfg[11:9] = EPF_CPL_SYNC;
		couplingOutputDrive[3] = 1'b1;
		cfg(3, 0, t[15:0], 4'h8, 2'd1, 1'b1, 1'b0);
		cfg(3, 1, t[15:0], 4'h8, 2'd0, 1'b0, 1'b0);
		machineStart[3] = 1'b1;
		tick(4);
		chk(machineState[11:9] === 3'd0, "coupled start alone");
		machineStart[2] = 1'b1;
		waitSt(3, 3'd1, 4, d);
		chk(d == 2, "coupled start");
		// Bench model of the dither accumulator: a carry adds one cycle to that state
		acc = 0;
		for (int k = 0; k < 4; k++) begin
			acc += ditherFracs[11:9];
			s = machineState[11:9];
			d = 0;
			while (machineState[11:9] === s && d < 40) begin
				chk(pwmOut[3] === 1'b0 && pwmOut[2] === (s == 3'd1), "merged output");
				tick(1);
				d++;
			end
			chk(d == t + 1 + acc / 8, "dithered length");
			acc %= 8;
		end
		rst_b = 1'b0;
		{machineStart, softEvent} = '0;
		tick(2);
		chk(machineState === '0 && pwmOut === '0 && irqLines === '0 && adcTrigger === 1'b0,
			"reset");
		rst_b = 1'b1;
		tick(2);
		final_report();
	end
endmodule
`default_nettype wire
